// File: logic/lrc_pkg.sv
// constants, types and states of the second rail control registers
package lrc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h65;
  localparam logic [7:0] ADDR_VSET = 8'h66;
  localparam logic [7:0] ADDR_CTRL = 8'h67;
  localparam logic [7:0] ADDR_SEQ = 8'h68;
  localparam logic [7:0] ADDR_RSVD = 8'h69;

  // status register: bit 5 limit status, bits 3:0 writable masks
  localparam int STAT_ILIM_BIT = 5;
  localparam int STAT_ILIM_MSK_BIT = 1;
  localparam int STAT_RW_W = 4;
  // control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_SLEEP_BIT = 6;
  localparam int CTRL_DEEP_BIT = 5;
  localparam int CTRL_ILIM_LO = 3;
  localparam int CTRL_RST_BIT = 2;
  localparam int CTRL_SHDN_BIT = 1;
  // sequencing register fields
  localparam int SEQ_LATCH_BIT = 7;
  localparam int SEQ_ON_DLY_LO = 5;
  localparam int SEQ_OFF_DLY_LO = 0;
  localparam int OFF_DLY_W = 5;

  // reset values
  localparam logic [7:0] VSET_RST = 8'h50;
  localparam logic [7:0] CTRL_RST = 8'h90;
  localparam logic [7:0] SEQ_RST = 8'h82;
  localparam logic [7:0] RSVD_RST = 8'h00;
  localparam logic [3:0] STAT_RW_RST = 4'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 250000;
  localparam int TICK_CYCLES_DEF = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_TIME_NS = 10000000;
  localparam int TICKS_W = 6;
  localparam int PRE_W = 24;
  localparam logic [TICKS_W-1:0] RETRY_TICKS = TICKS_W'(RETRY_TIME_NS / TICK_TIME_NS);
  localparam logic [TICKS_W-1:0] ON_DLY_1 = 6'h01;
  localparam logic [TICKS_W-1:0] ON_DLY_2 = 6'h02;
  localparam logic [TICKS_W-1:0] ON_DLY_3 = 6'h04;

  // rail sequencing states
  typedef enum logic [2:0] {
    ST_OFF, ST_ON_WAIT, ST_ON, ST_OFF_WAIT, ST_SLEEP_OFF, ST_RETRY
  } lrc_state_e;

  // turn-on delay code to quarter-millisecond ticks
  function automatic logic [TICKS_W-1:0] lrc_on_ticks(input logic [1:0] code);
    logic [TICKS_W-1:0] t;
    t = '0;
    unique case (code)
      2'h0: t = '0;
      2'h1: t = ON_DLY_1;
      2'h2: t = ON_DLY_2;
      2'h3: t = ON_DLY_3;
    endcase
    return t;
  endfunction

endpackage

// File: logic/lrc_rail_control_regs.sv
// register bank and on/off sequencing for the second low-dropout rail
`timescale 1ns/100ps
module lrc_rail_control_regs import lrc_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic CURRENT_OVER_LIMIT,
  input wire logic START_TRIGGER,
  input wire logic PREV_RAIL_OFF,
  input wire logic SLEEP_MODE,
  input wire logic DEEP_SLEEP_MODE,
  input wire logic BYPASS_MODE,
  output logic RAIL_ON,
  output logic [7:0] RAIL_VOLTAGE_CODE,
  output logic [1:0] RAIL_CURRENT_LIMIT_SELECT,
  output logic INTERRUPT_OUT_N,
  output logic SYSTEM_RESET_OUT_N
);

  typedef struct packed {
    logic [7:0] vset;
    logic [7:0] ctrl;
    logic [7:0] seq;
    logic [7:0] rsvd;
    logic [STAT_RW_W-1:0] stat_rw;
    logic ilim;
    logic rd_seen;
    logic irq_n;
    logic rst_n;
    logic rail_on;
    logic [7:0] vcode;
    logic [7:0] rdata;
    lrc_state_e st;
  } lrc_regs_s;

  lrc_regs_s q;
  lrc_regs_s n;
  lrc_timer_if tif();

  logic wr_status;
  logic rd_status;
  logic want_on;
  logic sleep_off;
  logic limit_shdn;
  logic mask_ilim;
  logic [TICKS_W-1:0] on_ticks;
  logic [TICKS_W-1:0] off_ticks;

  // ****************************************************************
  // decoded conditions
  // ****************************************************************
  // preceding rail shutdown only matters when the latch bit is clear
  assign wr_status = REG_WR && (REG_ADDR == ADDR_STATUS);
  assign rd_status = REG_RD && (REG_ADDR == ADDR_STATUS);
  assign want_on = q.ctrl[CTRL_EN_BIT] && START_TRIGGER
                   && !(!q.seq[SEQ_LATCH_BIT] && PREV_RAIL_OFF);
  assign sleep_off = (SLEEP_MODE && q.ctrl[CTRL_SLEEP_BIT])
                     || (DEEP_SLEEP_MODE && q.ctrl[CTRL_DEEP_BIT]);
  assign limit_shdn = CURRENT_OVER_LIMIT && q.ctrl[CTRL_SHDN_BIT];
  assign mask_ilim = q.stat_rw[STAT_ILIM_MSK_BIT];
  assign on_ticks = lrc_on_ticks(q.seq[SEQ_ON_DLY_LO +: 2]);
  assign off_ticks = TICKS_W'(q.seq[SEQ_OFF_DLY_LO +: OFF_DLY_W]);

  // ****************************************************************
  // register file, status and sequencer
  // ****************************************************************
  always_comb begin
    n = q;
    tif.start = 1'b0;
    tif.cancel = 1'b0;
    tif.ticks = '0;

    // register writes; the status bits above the masks are read-only
    if (REG_WR) begin
      unique case (REG_ADDR)
        ADDR_STATUS: n.stat_rw = REG_WDATA[STAT_RW_W-1:0];
        ADDR_VSET: n.vset = REG_WDATA;
        ADDR_CTRL: n.ctrl = REG_WDATA;
        ADDR_SEQ: n.seq = REG_WDATA;
        ADDR_RSVD: n.rsvd = REG_WDATA;
        default: n.rsvd = q.rsvd;
      endcase
    end

    // read data is captured on the read strobe and held until the next one
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_STATUS: begin
          n.rdata = '0;
          n.rdata[STAT_ILIM_BIT] = q.ilim;
          n.rdata[STAT_RW_W-1:0] = q.stat_rw;
        end
        ADDR_VSET: n.rdata = q.vset;
        ADDR_CTRL: n.rdata = q.ctrl;
        ADDR_SEQ: n.rdata = q.seq;
        ADDR_RSVD: n.rdata = q.rsvd;
        default: n.rdata = '0;
      endcase
    end

    // sticky limit flag: a new limit event wins over the read-clear
    n.rd_seen = q.rd_seen || (rd_status && q.ilim);
    n.ilim = CURRENT_OVER_LIMIT || (q.ilim && !n.rd_seen);
    if (!n.ilim) begin
      n.rd_seen = 1'b0;
    end
    if (wr_status && REG_WDATA[STAT_ILIM_MSK_BIT]) begin
      n.irq_n = 1'b1;
    end
    n.irq_n = !(n.ilim && !n.stat_rw[STAT_ILIM_MSK_BIT]);

    // bypass freezes the code handed to the regulator
    if (!BYPASS_MODE) begin
      n.vcode = q.vset;
    end

    // on/off sequencing; a lost enable overrides every pending delay except the retry wait
    unique case (q.st)
      ST_OFF: begin
        if (want_on) begin
          if (on_ticks == '0) begin
            n.st = ST_ON;
          end else begin
            tif.start = 1'b1;
            tif.ticks = on_ticks;
            n.st = ST_ON_WAIT;
          end
        end
      end
      ST_ON_WAIT: begin
        if (!want_on) begin
          tif.cancel = 1'b1;
          n.st = ST_OFF;
        end else if (tif.done) begin
          n.st = ST_ON;
        end
      end
      ST_ON: begin
        if (!want_on) begin
          n.st = ST_OFF;
        end else if (limit_shdn) begin
          tif.start = 1'b1;
          tif.ticks = RETRY_TICKS;
          n.st = ST_RETRY;
        end else if (sleep_off) begin
          if (off_ticks == '0) begin
            n.st = ST_SLEEP_OFF;
          end else begin
            tif.start = 1'b1;
            tif.ticks = off_ticks;
            n.st = ST_OFF_WAIT;
          end
        end
      end
      ST_OFF_WAIT: begin
        if (!want_on || !sleep_off) begin
          tif.cancel = 1'b1;
          n.st = want_on ? ST_ON : ST_OFF;
        end else if (tif.done) begin
          n.st = ST_SLEEP_OFF;
        end
      end
      ST_SLEEP_OFF: begin
        if (!want_on || !sleep_off) begin
          n.st = ST_OFF;
        end
      end
      ST_RETRY: begin
        // the restart still honours the turn-on delay through the off state
        if (tif.done) begin
          n.st = ST_OFF;
        end
      end
    endcase

    n.rail_on = (n.st == ST_ON) || (n.st == ST_OFF_WAIT);
    n.rst_n = !(q.ctrl[CTRL_RST_BIT] && !n.rail_on);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      q <= '{vset: VSET_RST, ctrl: CTRL_RST, seq: SEQ_RST, rsvd: RSVD_RST,
             stat_rw: STAT_RW_RST, ilim: 1'b0, rd_seen: 1'b0, irq_n: 1'b1,
             rst_n: 1'b1, rail_on: 1'b0, vcode: VSET_RST, rdata: 8'h00,
             st: ST_OFF};
    end else begin
      q <= n;
    end
  end

  lrc_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N),
    .tif(tif.timer)
  );

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  assign REG_RDATA = q.rdata;
  assign RAIL_ON = q.rail_on;
  assign RAIL_VOLTAGE_CODE = q.vcode;
  assign RAIL_CURRENT_LIMIT_SELECT = q.ctrl[CTRL_ILIM_LO +: 2];
  assign INTERRUPT_OUT_N = q.irq_n;
  assign SYSTEM_RESET_OUT_N = q.rst_n;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  a_mask_blocks_irq: assert property (mask_ilim |-> INTERRUPT_OUT_N)
    else $error("masked limit drove interrupt low");
  a_status_still_set: assert property (CURRENT_OVER_LIMIT |=> q.ilim)
    else $error("limit status not reported");
  a_irq_on_limit: assert property (CURRENT_OVER_LIMIT && !$past(mask_ilim) && !mask_ilim
    && !wr_status |=> !INTERRUPT_OUT_N)
    else $error("unmasked limit did not pull interrupt low");
  a_status_sticky: assert property (q.ilim && !q.rd_seen && !rd_status |=> q.ilim)
    else $error("limit status cleared without a read");
  a_bypass_freeze: assert property (BYPASS_MODE |=> $stable(RAIL_VOLTAGE_CODE))
    else $error("voltage code changed in bypass");
  a_enable_off: assert property (!q.ctrl[CTRL_EN_BIT] |=> !RAIL_ON)
    else $error("rail on while disabled");
  a_sleep_off: assert property (q.st == ST_ON && want_on && !limit_shdn && sleep_off
    && off_ticks == '0 |=> !RAIL_ON)
    else $error("rail stayed on entering sleep");
  a_reset_influence: assert property (q.ctrl[CTRL_RST_BIT] && $past(q.ctrl[CTRL_RST_BIT])
    && !RAIL_ON |-> !SYSTEM_RESET_OUT_N)
    else $error("rail off did not pull reset");
  a_limit_shutdown: assert property (q.st == ST_ON && want_on && limit_shdn
    |=> !RAIL_ON ##0 q.st == ST_RETRY)
    else $error("rail kept running in limit with shutdown set");
  a_seq_follow: assert property (!q.seq[SEQ_LATCH_BIT] && PREV_RAIL_OFF |=> !RAIL_ON)
    else $error("rail ignored preceding rail shutdown");
  a_on_delay_zero: assert property (q.st == ST_OFF && want_on && on_ticks == '0
    |=> RAIL_ON)
    else $error("zero turn-on delay not immediate");

  c_rail_up: cover property ($rose(RAIL_ON));
  c_irq_low: cover property ($fell(INTERRUPT_OUT_N));
  c_retry: cover property (q.st == ST_RETRY ##1 q.st == ST_OFF);
  c_sleep_off: cover property (q.st == ST_OFF_WAIT ##1 q.st == ST_SLEEP_OFF);

endmodule

// File: logic/lrc_tick_timer.sv
// delay timer counting whole quarter-millisecond ticks
`timescale 1ns/100ps
module lrc_tick_timer import lrc_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  lrc_timer_if.timer tif
);

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [TICKS_W-1:0] left;
    logic busy;
    logic done;
  } lrc_tmr_s;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  lrc_tmr_s q;
  lrc_tmr_s n;

  // ****************************************************************
  // prescaler and tick countdown
  // ****************************************************************
  // a restart reloads the count so a new delay never inherits a partial tick
  always_comb begin
    n = q;
    n.done = 1'b0;
    if (tif.cancel) begin
      n.busy = 1'b0;
    end else if (tif.start) begin
      n.pre = '0;
      n.left = tif.ticks;
      n.busy = 1'b1;
    end else if (q.busy) begin
      if (q.pre == PRE_LAST) begin
        n.pre = '0;
        n.left = q.left - 1'b1;
        if (q.left == ON_DLY_1) begin
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end else begin
        n.pre = q.pre + 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tif.done = q.done;
  assign tif.busy = q.busy;

endmodule

// File: logic/lrc_timer_if.sv
// carrier between the rail sequencer and its delay timer
`timescale 1ns/100ps
interface lrc_timer_if;
  import lrc_pkg::*;
  logic start;
  logic cancel;
  logic [TICKS_W-1:0] ticks;
  logic done;
  logic busy;
  modport master (output start, output cancel, output ticks, input done, input busy);
  modport timer (input start, input cancel, input ticks, output done, output busy);
endinterface

// File: tb/lrc_load_model.sv
// behavioural load and limit comparator at the far side of the second rail
`timescale 1ns/100ps
module lrc_load_model (
  input wire logic CORE_CLK,
  input wire logic RAIL_ON,
  input wire logic [1:0] RAIL_CURRENT_LIMIT_SELECT,
  input wire logic [9:0] LOAD_MA,
  output logic CURRENT_OVER_LIMIT = 1'b0
);
  logic [9:0] lim_ma;
  // limit in milliamps for each select code
  always_comb begin
    case (RAIL_CURRENT_LIMIT_SELECT)
      2'h0: lim_ma = 10'h09B;
      2'h1: lim_ma = 10'h0F5;
      2'h2: lim_ma = 10'h16D;
      default: lim_ma = 10'h1CC;
    endcase
  end
  // an off rail draws nothing, so the comparator trips only while on
  always @(posedge CORE_CLK) begin
    CURRENT_OVER_LIMIT <= RAIL_ON && (LOAD_MA > lim_ma);
  end
endmodule

// File: tb/tb.sv
// self-checking bench for the second rail control registers
`timescale 1ns/100ps
module tb;
  import lrc_pkg::*;
  localparam int TK = 8;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic [7:0] REG_RDATA;
  logic CURRENT_OVER_LIMIT;
  logic START_TRIGGER = 1'b0;
  logic PREV_RAIL_OFF = 1'b0;
  logic SLEEP_MODE = 1'b0;
  logic DEEP_SLEEP_MODE = 1'b0;
  logic BYPASS_MODE = 1'b0;
  logic RAIL_ON;
  logic [7:0] RAIL_VOLTAGE_CODE;
  logic [1:0] RAIL_CURRENT_LIMIT_SELECT;
  logic INTERRUPT_OUT_N;
  logic SYSTEM_RESET_OUT_N;
  logic [9:0] load_ma = 10'h000;
  logic [7:0] rd_val;
  int n_errors = 0;
  int n_checks = 0;
  int cnt;
  int on_t[4] = '{0, 1, 2, 4};

  // short tick of eight cycles keeps millisecond delays to 32 cycles each
  lrc_rail_control_regs #(.TICK_CYCLES(TK)) lrc_rail_control_regs_inst (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CURRENT_OVER_LIMIT(CURRENT_OVER_LIMIT), .START_TRIGGER(START_TRIGGER),
    .PREV_RAIL_OFF(PREV_RAIL_OFF), .SLEEP_MODE(SLEEP_MODE),
    .DEEP_SLEEP_MODE(DEEP_SLEEP_MODE), .BYPASS_MODE(BYPASS_MODE), .RAIL_ON(RAIL_ON),
    .RAIL_VOLTAGE_CODE(RAIL_VOLTAGE_CODE),
    .RAIL_CURRENT_LIMIT_SELECT(RAIL_CURRENT_LIMIT_SELECT),
    .INTERRUPT_OUT_N(INTERRUPT_OUT_N), .SYSTEM_RESET_OUT_N(SYSTEM_RESET_OUT_N));
  lrc_load_model lrc_load_model_inst (
    .CORE_CLK(CORE_CLK), .RAIL_ON(RAIL_ON),
    .RAIL_CURRENT_LIMIT_SELECT(RAIL_CURRENT_LIMIT_SELECT), .LOAD_MA(load_ma),
    .CURRENT_OVER_LIMIT(CURRENT_OVER_LIMIT));

  // 40 MHz core clock
  always #12.5 CORE_CLK = ~CORE_CLK;

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask
  // read data is registered, so it is taken one edge after the strobe drops
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    @(posedge CORE_CLK);
    #1 rd_val = REG_RDATA;
    chk(what, rd_val, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  // bounded wait, cnt gives the cycles it took
  task automatic wait_rail(input logic v, input int lim);
    cnt = 0;
    while (RAIL_ON !== v && cnt < lim) begin
      @(posedge CORE_CLK);
      #1 cnt++;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    rchk(8'h65, 8'h00, "status");
    rchk(8'h66, 8'h50, "vset");
    rchk(8'h67, 8'h90, "ctrl");
    rchk(8'h68, 8'h82, "seq");
    rchk(8'h69, 8'h00, "rsvd");
    rchk(8'h70, 8'h00, "unmapped");
    wr(8'h69, 8'h5A);
    wr(8'h70, 8'hFF);
    rchk(8'h69, 8'h5A, "rsvd_rw");
    rchk(8'h70, 8'h00, "unmapped_wr");
    wr(8'h65, 8'hF3);
    rchk(8'h65, 8'h03, "status_ro");
    wr(8'h65, 8'h00);
    // code reaches the regulator, bypass freezes it
    wr(8'h66, 8'hA5);
    idle(2);
    chk("vcode", RAIL_VOLTAGE_CODE, 8'hA5);
    @(posedge CORE_CLK) BYPASS_MODE <= 1'b1;
    wr(8'h66, 8'h3C);
    idle(2);
    chk("vcode_bypass", RAIL_VOLTAGE_CODE, 8'hA5);
    @(posedge CORE_CLK) BYPASS_MODE <= 1'b0;
    idle(2);
    chk("vcode_after", RAIL_VOLTAGE_CODE, 8'h3C);
    for (int i = 0; i < 4; i++) begin
      wr(8'h67, 8'h80 | 8'(i << 3));
      idle(1);
      chk("lim_sel", {6'h00, RAIL_CURRENT_LIMIT_SELECT}, 8'(i));
    end
    wr(8'h67, 8'h90);
    // every turn-on delay code, measured from the trigger
    for (int i = 0; i < 4; i++) begin
      @(posedge CORE_CLK) START_TRIGGER <= 1'b0;
      wr(8'h68, 8'h82 | 8'(i << 5));
      @(posedge CORE_CLK) START_TRIGGER <= 1'b1;
      wait_rail(1'b1, 60);
      chk("on_dly", {7'h00, cnt >= on_t[i] * TK && cnt <= on_t[i] * TK + 5}, 8'h01);
    end
    wr(8'h68, 8'h82);
    wr(8'h67, 8'h10);
    idle(1);
    chk("rail_dis", {7'h00, RAIL_ON}, 8'h00);
    chk("rst_free", {7'h00, SYSTEM_RESET_OUT_N}, 8'h01);
    wr(8'h67, 8'h14);
    idle(1);
    chk("rst_pull", {7'h00, SYSTEM_RESET_OUT_N}, 8'h00);
    wr(8'h67, 8'h94);
    wait_rail(1'b1, 10);
    chk("rst_on", {7'h00, SYSTEM_RESET_OUT_N}, 8'h01);
    wr(8'h67, 8'h90);
    @(posedge CORE_CLK) PREV_RAIL_OFF <= 1'b1;
    idle(4);
    chk("latch_hold", {7'h00, RAIL_ON}, 8'h01);
    wr(8'h68, 8'h02);
    wait_rail(1'b0, 5);
    chk("latch_off", {7'h00, RAIL_ON}, 8'h00);
    wr(8'h68, 8'h82);
    wait_rail(1'b1, 10);
    @(posedge CORE_CLK) PREV_RAIL_OFF <= 1'b0;
    @(posedge CORE_CLK) SLEEP_MODE <= 1'b1;
    idle(40);
    chk("sleep_stay", {7'h00, RAIL_ON}, 8'h01);
    @(posedge CORE_CLK) SLEEP_MODE <= 1'b0;
    wr(8'h67, 8'hD0);
    // turn-off delay field 0, 4 and 8 quarter ticks
    for (int k = 0; k < 9; k += 4) begin
      wr(8'h68, 8'h80 | 8'(k));
      @(posedge CORE_CLK) SLEEP_MODE <= 1'b1;
      wait_rail(1'b0, 100);
      chk("off_dly", {7'h00, cnt >= k * TK && cnt <= k * TK + 4}, 8'h01);
      @(posedge CORE_CLK) SLEEP_MODE <= 1'b0;
      wait_rail(1'b1, 20);
    end
    wr(8'h67, 8'hB0);
    @(posedge CORE_CLK) DEEP_SLEEP_MODE <= 1'b1;
    // the off-delay field still holds eight quarter ticks from the loop above
    wait_rail(1'b0, 80);
    chk("deep_off", {7'h00, RAIL_ON}, 8'h00);
    chk("deep_dly", {7'h00, cnt >= 8 * TK && cnt <= 8 * TK + 4}, 8'h01);
    @(posedge CORE_CLK) DEEP_SLEEP_MODE <= 1'b0;
    wr(8'h67, 8'h90);
    wait_rail(1'b1, 20);
    // unmasked limit: low until the current drops and the bit is read
    @(posedge CORE_CLK) load_ma <= 10'h190;
    idle(3);
    chk("irq_set", {7'h00, INTERRUPT_OUT_N}, 8'h00);
    chk("keep_run", {7'h00, RAIL_ON}, 8'h01);
    @(posedge CORE_CLK) load_ma <= 10'h064;
    idle(3);
    chk("irq_unread", {7'h00, INTERRUPT_OUT_N}, 8'h00);
    rchk(8'h65, 8'h20, "stat_set");
    idle(1);
    chk("irq_clr", {7'h00, INTERRUPT_OUT_N}, 8'h01);
    rchk(8'h65, 8'h00, "stat_clr");
    wr(8'h65, 8'h02);
    @(posedge CORE_CLK) load_ma <= 10'h190;
    idle(3);
    chk("irq_masked", {7'h00, INTERRUPT_OUT_N}, 8'h01);
    rchk(8'h65, 8'h22, "stat_masked");
    @(posedge CORE_CLK) load_ma <= 10'h064;
    idle(3);
    rchk(8'h65, 8'h02, "stat_mclr");
    wr(8'h65, 8'h00);
    // shutdown on limit then restart after forty ticks
    wr(8'h67, 8'h92);
    @(posedge CORE_CLK) load_ma <= 10'h190;
    wait_rail(1'b0, 6);
    chk("shdn_off", {7'h00, RAIL_ON}, 8'h00);
    @(posedge CORE_CLK) load_ma <= 10'h064;
    wait_rail(1'b1, 400);
    chk("retry", {7'h00, cnt >= 40 * TK - 4 && cnt <= 40 * TK + 6}, 8'h01);
    rchk(8'h65, 8'h20, "stat_retry");
    tally_and_finish();
  end

  // watchdog at 16000 cycles, well beyond the fewer than a thousand cycles the scenarios need
  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end
endmodule
